// *** telegram_pkg.sv ***
// constants, register map and state encoding of the supply-line telegram decoder
// assumes a 20 MHz core clock and one telegram decoder per sensor
package telegram_pkg;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_KHZ = 20000;
  localparam int TP0_MIN_US = 1700;
  localparam int TP0_MAX_US = 1900;
  localparam int TPOUT_US = 3000;
  localparam int TP1_PERCENT = 65;
  localparam int TPROG_MS = 100;
  localparam int TP0_MIN_CYC = (TP0_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int TP0_MAX_CYC = TP0_MAX_US * CLK_KHZ / 1000;
  localparam int TPOUT_CYC = TPOUT_US * CLK_KHZ / 1000;
  localparam int TPROG_CYC = TPROG_MS * CLK_KHZ;

  // ********************************
  // telegram layout
  // ********************************
  localparam int PAYLOAD_W = 14;
  localparam logic [4:0] HEADER_BITS = 5'h09;
  localparam logic [4:0] WRITE_BITS = 5'h18;
  localparam logic [4:0] READ_REPLY_BITS = 5'h10;
  localparam logic [4:0] ACK_REPLY_BITS = 5'h01;
  localparam logic [11:0] DEACT_KEY = 12'h80F;
  localparam int LOCK_BIT = 0;

  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_PROGRAM = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;

  // ********************************
  // register select codes
  // ********************************
  localparam logic [3:0] ADDR_LOW_CLAMP = 4'h1;
  localparam logic [3:0] ADDR_HIGH_CLAMP = 4'h2;
  localparam logic [3:0] ADDR_QUIESCENT = 4'h3;
  localparam logic [3:0] ADDR_GAIN = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_PROTECT = 4'h6;
  localparam logic [3:0] ADDR_ADC = 4'h7;
  localparam logic [3:0] ADDR_SCRATCH_UPPER = 4'h8;
  localparam logic [3:0] ADDR_DAC = 4'h9;
  localparam logic [3:0] ADDR_TEMP_COEFF = 4'hB;
  localparam logic [3:0] ADDR_SCRATCH_FIRST = 4'hC;
  localparam logic [3:0] ADDR_DISABLE = 4'hF;
  // storage slots of the three upper scratch words (unused select codes)
  localparam logic [3:0] SLOT_SCRATCH_1 = 4'h0;
  localparam logic [3:0] SLOT_SCRATCH_2 = 4'hA;
  localparam logic [3:0] SLOT_SCRATCH_3 = 4'hD;

  function automatic logic [3:0] reg_width(input logic [3:0] a);
    unique case (a)
      ADDR_LOW_CLAMP: reg_width = 4'h8;
      ADDR_HIGH_CLAMP: reg_width = 4'h9;
      ADDR_QUIESCENT: reg_width = 4'hB;
      ADDR_GAIN, ADDR_ADC, ADDR_DAC: reg_width = 4'hE;
      ADDR_CONFIG, ADDR_TEMP_COEFF: reg_width = 4'hA;
      ADDR_PROTECT: reg_width = 4'h2;
      ADDR_SCRATCH_UPPER, ADDR_SCRATCH_FIRST: reg_width = 4'hD;
      ADDR_DISABLE: reg_width = 4'hC;
      default: reg_width = 4'h0;
    endcase
  endfunction

  typedef enum logic [3:0] {
    ST_IDLE, ST_SYNC, ST_BIT_HI, ST_BIT_LO, ST_EXEC, ST_TX, ST_PROG, ST_QUIET, ST_OFF
  } state_t;

endpackage

// *** sensor_programming_telegram.sv ***
// telegram decoder: supply-line commands in, acknowledge and read data out on the output pin
// assumes supply_high_i is a comparator level from the pin, out_pin_i the pin readback
// How it works
// - sync pulse (logic zero) starts a telegram; its length sets the input bit period
// - opcode parity is one when the three opcode bits hold an odd zero count
// - select parity is one when the four select bits hold an odd zero count
// - write telegrams carry a fourteen-bit payload; read telegrams end after the nine header bits
// - writes keep only the trailing payload bits, as many as the register width
// - reads place the register value in the leading payload bits, zeros trailing
// - payload parity is one when the payload holds an even zero count
// - each accepted telegram is answered by a zero acknowledge bit setting reply timing
// - opcode 2 reads, 3 writes, 4 programs all non-volatile words from RAM
// - opcode 5 erases every non-volatile word at once
// - values travel most significant bit first
// - sign-magnitude registers are stored bit for bit, sign leading
// - two's-complement registers are stored bit for bit, sign leading
// - temperature coefficient splits into group, linear and three-bit quadratic fields
// - configuration packs range bits 9 and 2:1, output select 8:5, filter 4:3
// - configuration sits at select 5, ten bits wide, read, write and program
// - select 9 returns the fourteen-bit output converter value bit reversed
// - only the key 80F written to select 15 deactivates the sensor
// - a deactivated sensor wakes on an activate pulse on the pin or power cycle
// - erase and program need select zero and act on all words together
// - a stored lock bit takes effect at the next power-up and blocks programming
module sensor_programming_telegram #(
  parameter int TP0_MIN_CYCLES = telegram_pkg::TP0_MIN_CYC,
  parameter int TP0_MAX_CYCLES = telegram_pkg::TP0_MAX_CYC,
  parameter int TPOUT_CYCLES = telegram_pkg::TPOUT_CYC,
  parameter int TPROG_CYCLES = telegram_pkg::TPROG_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // supply line and output pin
  input wire logic supply_high_i,
  input wire logic out_pin_i,
  output logic out_pin_o,
  output logic out_pin_oe_o,
  // readouts from the signal path
  input wire logic [13:0] adc_sample_i,
  input wire logic [13:0] dac_value_i,
  // status
  output logic sensor_active_o,
  output logic lock_active_o,
  output logic prog_busy_o,
  // calibration values to the signal path
  output logic [7:0] low_clamp_level_o,
  output logic [8:0] high_clamp_level_o,
  output logic [10:0] quiescent_output_offset_o,
  output logic [13:0] gain_setting_o,
  output logic [2:0] range_select_o,
  output logic [3:0] output_behaviour_select_o,
  output logic [1:0] filter_select_o,
  output logic [1:0] tc_group_o,
  output logic [4:0] tc_linear_o,
  output logic [2:0] quadratic_temp_coefficient_o
);

  // ********************************
  // constants and state
  // ********************************
  localparam logic [21:0] TPOUT_LEN = 22'(TPOUT_CYCLES);
  localparam logic [21:0] TP1_HIGH = 22'(TPOUT_CYCLES * telegram_pkg::TP1_PERCENT / 100);
  localparam logic [21:0] TP0_LOW = TPOUT_LEN - TP1_HIGH;
  localparam logic [21:0] SYNC_MIN = 22'(TP0_MIN_CYCLES);
  localparam logic [21:0] SYNC_MAX = 22'(TP0_MAX_CYCLES);
  localparam logic [21:0] PROG_LEN = 22'(TPROG_CYCLES);

  typedef struct packed {
    telegram_pkg::state_t st;
    logic [21:0] cnt;
    logic [16:0] period;
    logic [4:0] bitn;
    logic [23:0] rx;
    logic [15:0] tx;
    logic [4:0] txn;
    logic [1:0] gp_ptr;
    logic [15:0][13:0] ram;
    logic active;
    logic lock_active;
    logic boot;
    logic prog_pending;
    logic erase_pending;
    logic deact_pending;
    logic pin_drive;
    logic pin_level;
    logic sup_meta;
    logic sup_s;
    logic sup_d;
    logic act_meta;
    logic act_s;
  } core_t;

  core_t s;
  core_t next_s;
  logic [1:0] rst_sync;
  logic rst_n;
  // non-volatile image: survives reset, so it keeps no reset term
  logic [15:0][13:0] nvm;
  logic nvm_program;
  logic nvm_erase;

  // ********************************
  // reset release
  // ********************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ********************************
  // helpers
  // ********************************
  function automatic logic [3:0] slot_of(input logic [3:0] a, input logic [1:0] p);
    if (a == telegram_pkg::ADDR_SCRATCH_UPPER) begin
      unique case (p)
        2'h0: slot_of = telegram_pkg::SLOT_SCRATCH_1;
        2'h1: slot_of = telegram_pkg::SLOT_SCRATCH_2;
        default: slot_of = telegram_pkg::SLOT_SCRATCH_3;
      endcase
    end else begin
      slot_of = a;
    end
  endfunction

  function automatic logic [13:0] reverse14(input logic [13:0] v);
    logic [13:0] r;
    r = 14'h0;
    for (int i = 0; i < 14; i++) begin
      r[i] = v[13 - i];
    end
    return r;
  endfunction

  // ********************************
  // next state
  // ********************************
  logic rise;
  logic fall;
  logic [21:0] timeout;
  logic [8:0] hdr;
  logic [2:0] op;
  logic [3:0] ad;
  logic [3:0] slot;
  logic [3:0] w;
  logic [13:0] data;
  logic [13:0] mask;
  logic [13:0] value;
  logic [13:0] payload;
  logic hdr_ok;
  logic accept;
  logic bitv;
  logic [23:0] rx_shift;
  logic [4:0] bitn_inc;
  logic [21:0] hold;

  always_comb begin
    next_s = s;
    nvm_program = 1'b0;
    nvm_erase = 1'b0;
    next_s.sup_meta = supply_high_i;
    next_s.sup_s = s.sup_meta;
    next_s.sup_d = s.sup_s;
    next_s.act_meta = out_pin_i;
    next_s.act_s = s.act_meta;
    rise = s.sup_s & ~s.sup_d;
    fall = ~s.sup_s & s.sup_d;
    timeout = {4'h0, s.period, 1'b0};
    next_s.cnt = s.cnt + 22'h1;
    // header sits at the front of the shift register for a 24-bit telegram, in the low nine bits for a 9-bit one
    hdr = (s.bitn == telegram_pkg::WRITE_BITS) ? s.rx[23:15] : s.rx[8:0];
    op = hdr[8:6];
    ad = hdr[4:1];
    data = s.rx[14:1];
    hdr_ok = (hdr[5] == ^(~op)) && (hdr[0] == ^(~ad));
    slot = slot_of(ad, s.gp_ptr);
    w = telegram_pkg::reg_width(ad);
    mask = 14'((15'h1 << w) - 15'h1);
    value = s.ram[slot];
    payload = 14'h0;
    accept = 1'b0;
    bitv = ({5'h0, s.cnt} > {6'h0, s.period[16:1]});
    rx_shift = {s.rx[22:0], bitv};
    bitn_inc = s.bitn + 5'h1;
    hold = s.tx[15] ? TP1_HIGH : TP0_LOW;
    if (!s.boot) begin
      // lock is sampled from the stored image only at power-up
      next_s.boot = 1'b1;
      next_s.ram = nvm;
      // a never-programmed image reads as unlocked
      if (nvm[telegram_pkg::ADDR_PROTECT][telegram_pkg::LOCK_BIT]) begin
        next_s.lock_active = 1'b1;
      end
    end
    unique case (s.st)
      telegram_pkg::ST_IDLE: begin
        next_s.cnt = 22'h0;
        next_s.pin_drive = 1'b0;
        if (rise) begin
          next_s.st = telegram_pkg::ST_SYNC;
        end
      end
      telegram_pkg::ST_SYNC: begin
        if (rise) begin
          // rising edge to rising edge is the bit period
          next_s.cnt = 22'h0;
          next_s.bitn = 5'h0;
          if (s.cnt >= SYNC_MIN && s.cnt <= SYNC_MAX) begin
            next_s.period = s.cnt[16:0];
            next_s.st = telegram_pkg::ST_BIT_HI;
          end else begin
            next_s.st = telegram_pkg::ST_QUIET;
          end
        end else if (s.cnt > {SYNC_MAX[20:0], 1'b0}) begin
          next_s.st = telegram_pkg::ST_IDLE;
        end
      end
      telegram_pkg::ST_BIT_HI: begin
        if (fall) begin
          // bits shift in msb first
          next_s.rx = rx_shift;
          next_s.bitn = bitn_inc;
          next_s.cnt = 22'h0;
          next_s.st = telegram_pkg::ST_BIT_LO;
          if ((bitn_inc == telegram_pkg::HEADER_BITS && rx_shift[8:6] != telegram_pkg::OP_WRITE) ||
              bitn_inc == telegram_pkg::WRITE_BITS) begin
            next_s.st = telegram_pkg::ST_EXEC;
          end
        end else if (s.cnt >= timeout) begin
          next_s.st = telegram_pkg::ST_QUIET;
        end
      end
      telegram_pkg::ST_BIT_LO: begin
        if (rise) begin
          next_s.cnt = 22'h0;
          next_s.st = telegram_pkg::ST_BIT_HI;
        end else if (s.cnt >= timeout) begin
          // a stalled telegram is dropped, not finished
          next_s.st = telegram_pkg::ST_IDLE;
        end
      end
      telegram_pkg::ST_EXEC: begin
        next_s.cnt = 22'h0;
        next_s.tx = 16'h0;
        next_s.txn = telegram_pkg::ACK_REPLY_BITS;
        // anything unlisted falls through unanswered
        unique case (op)
          telegram_pkg::OP_READ: begin
            if (hdr_ok && w != 4'h0 && ad != telegram_pkg::ADDR_DISABLE) begin
              if (ad == telegram_pkg::ADDR_ADC) begin
                value = adc_sample_i;
              end else if (ad == telegram_pkg::ADDR_DAC) begin
                value = reverse14(dac_value_i);
              end
              payload = 14'((value & mask) << (4'hE - w));
              next_s.tx = {1'b0, payload, ~^payload};
              next_s.txn = telegram_pkg::READ_REPLY_BITS;
              accept = 1'b1;
            end
          end
          telegram_pkg::OP_WRITE: begin
            if (hdr_ok && s.rx[0] == ~^data && w != 4'h0 &&
                ad != telegram_pkg::ADDR_ADC && ad != telegram_pkg::ADDR_DAC) begin
              accept = 1'b1;
              if (ad == telegram_pkg::ADDR_DISABLE) begin
                next_s.deact_pending = (data[11:0] == telegram_pkg::DEACT_KEY);
              end else begin
                // stored bit for bit
                next_s.ram[slot] = data & mask;
              end
            end
          end
          telegram_pkg::OP_PROGRAM, telegram_pkg::OP_ERASE: begin
            if (hdr_ok && ad == 4'h0 && !s.lock_active) begin
              accept = 1'b1;
              next_s.prog_pending = (op == telegram_pkg::OP_PROGRAM);
              next_s.erase_pending = (op == telegram_pkg::OP_ERASE);
            end
          end
          default: begin
            accept = 1'b0;
          end
        endcase
        if (accept && (op == telegram_pkg::OP_READ || op == telegram_pkg::OP_WRITE)) begin
          // scratch pointer follows the access order
          if (ad == telegram_pkg::ADDR_SCRATCH_FIRST) begin
            next_s.gp_ptr = 2'h0;
          end else if (ad == telegram_pkg::ADDR_SCRATCH_UPPER) begin
            next_s.gp_ptr = (s.gp_ptr == 2'h2) ? 2'h0 : s.gp_ptr + 2'h1;
          end
        end
        next_s.st = accept ? telegram_pkg::ST_TX : telegram_pkg::ST_QUIET;
      end
      telegram_pkg::ST_TX: begin
        // first bit is the zero acknowledge; level lags cnt by one cycle
        next_s.pin_drive = 1'b1;
        next_s.pin_level = (s.cnt < hold);
        if (s.cnt == TPOUT_LEN - 22'h1) begin
          next_s.cnt = 22'h0;
          next_s.tx = {s.tx[14:0], 1'b0};
          next_s.txn = s.txn - 5'h1;
          if (s.txn == 5'h1) begin
            next_s.pin_drive = 1'b0;
            next_s.pin_level = 1'b0;
            if (s.deact_pending) begin
              next_s.deact_pending = 1'b0;
              next_s.active = 1'b0;
              next_s.st = telegram_pkg::ST_OFF;
            end else if (s.prog_pending || s.erase_pending) begin
              next_s.st = telegram_pkg::ST_PROG;
            end else begin
              next_s.st = telegram_pkg::ST_QUIET;
            end
          end
        end
      end
      telegram_pkg::ST_PROG: begin
        // supply carries the programming voltage here, so edges are ignored
        if (s.cnt >= PROG_LEN) begin
          nvm_program = s.prog_pending;
          nvm_erase = s.erase_pending;
          next_s.prog_pending = 1'b0;
          next_s.erase_pending = 1'b0;
          next_s.cnt = 22'h0;
          next_s.st = telegram_pkg::ST_QUIET;
        end
      end
      telegram_pkg::ST_QUIET: begin
        if (rise) begin
          next_s.cnt = 22'h0;
        end else if (s.cnt >= {SYNC_MAX[20:0], 1'b0}) begin
          next_s.st = telegram_pkg::ST_IDLE;
        end
      end
      telegram_pkg::ST_OFF: begin
        // pin is not driven here, so any high comes from outside
        next_s.cnt = 22'h0;
        if (s.act_s) begin
          next_s.active = 1'b1;
          next_s.st = telegram_pkg::ST_QUIET;
        end
      end
      default: begin
        next_s.st = telegram_pkg::ST_IDLE;
      end
    endcase
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= telegram_pkg::ST_IDLE;
      s.active <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // erase and program touch every word in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (nvm_erase) begin
      nvm <= '0;
    end else if (nvm_program) begin
      nvm <= s.ram;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign out_pin_o = s.pin_level;
  assign out_pin_oe_o = s.pin_drive;
  assign sensor_active_o = s.active;
  assign lock_active_o = s.lock_active;
  assign prog_busy_o = (s.st == telegram_pkg::ST_PROG);
  assign low_clamp_level_o = s.ram[telegram_pkg::ADDR_LOW_CLAMP][7:0];
  assign high_clamp_level_o = s.ram[telegram_pkg::ADDR_HIGH_CLAMP][8:0];
  assign quiescent_output_offset_o = s.ram[telegram_pkg::ADDR_QUIESCENT][10:0];
  assign gain_setting_o = s.ram[telegram_pkg::ADDR_GAIN];
  assign range_select_o = {s.ram[telegram_pkg::ADDR_CONFIG][9], s.ram[telegram_pkg::ADDR_CONFIG][2:1]};
  assign output_behaviour_select_o = s.ram[telegram_pkg::ADDR_CONFIG][8:5];
  assign filter_select_o = s.ram[telegram_pkg::ADDR_CONFIG][4:3];
  assign tc_group_o = s.ram[telegram_pkg::ADDR_TEMP_COEFF][9:8];
  assign tc_linear_o = s.ram[telegram_pkg::ADDR_TEMP_COEFF][7:3];
  assign quadratic_temp_coefficient_o = s.ram[telegram_pkg::ADDR_TEMP_COEFF][2:0];

endmodule

// *** telegram_sva.sv ***
// checker for the supply-line telegram decoder, watching its pins and status outputs only
// assumes one core clock and the raw active-low reset at the top ports
module telegram_sva #(
  parameter int TPOUT_CYCLES = 100,
  parameter int TPROG_CYCLES = 50
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // pins
  input wire logic supply_high_i,
  input wire logic out_pin_i,
  input wire logic out_pin_o,
  input wire logic out_pin_oe_o,
  // status
  input wire logic sensor_active_o,
  input wire logic lock_active_o,
  input wire logic prog_busy_o
);
  // ********************************
  // helper counters
  // ********************************
  int hi_cnt;
  int busy_cnt;
  int up_cnt;
  int pos;
  assign pos = hi_cnt % TPOUT_CYCLES;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_cnt <= 0;
      busy_cnt <= 0;
      up_cnt <= 0;
    end else begin
      hi_cnt <= out_pin_oe_o ? hi_cnt + 1 : 0;
      busy_cnt <= prog_busy_o ? busy_cnt + 1 : 0;
      up_cnt <= (up_cnt < 15) ? up_cnt + 1 : up_cnt;
    end
  end
  // ********************************
  // properties
  // ********************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // margins of a few percent absorb the one-cycle pin lag
  bit_start_high_a: assert property (out_pin_oe_o && pos >= 2 && pos <= TPOUT_CYCLES * 30 / 100 |-> out_pin_o)
    else $error("reply bit does not start high");
  bit_tail_low_a: assert property (out_pin_oe_o && pos >= TPOUT_CYCLES * 70 / 100
    && pos <= TPOUT_CYCLES * 95 / 100 |-> !out_pin_o)
    else $error("reply bit tail not low");
  ack_zero_bit_a: assert property (out_pin_oe_o && hi_cnt >= TPOUT_CYCLES * 40 / 100
    && hi_cnt <= TPOUT_CYCLES * 95 / 100 |-> !out_pin_o)
    else $error("acknowledge is not a zero bit");
  reply_length_a: assert property ($fell(out_pin_oe_o) |-> (hi_cnt >= TPOUT_CYCLES - 1 && hi_cnt <= TPOUT_CYCLES + 1)
    || (hi_cnt >= 16 * TPOUT_CYCLES - 1 && hi_cnt <= 16 * TPOUT_CYCLES + 1))
    else $error("reply length is neither ack nor read");
  reply_cause_a: assert property ($rose(out_pin_oe_o) |-> !supply_high_i && sensor_active_o && !prog_busy_o)
    else $error("reply started while not allowed");
  deact_after_ack_a: assert property ($fell(sensor_active_o) |-> !out_pin_oe_o)
    else $error("deactivated before acknowledge ended");
  wake_on_pulse_a: assert property ($rose(out_pin_i) && !sensor_active_o && !out_pin_oe_o
    |-> ##[1:6] sensor_active_o)
    else $error("activate pulse did not wake sensor");
  busy_length_a: assert property ($fell(prog_busy_o) |-> busy_cnt >= TPROG_CYCLES - 1
    && busy_cnt <= TPROG_CYCLES + 1)
    else $error("program wait has wrong length");
  busy_no_reply_a: assert property (prog_busy_o |-> !out_pin_oe_o)
    else $error("reply during program wait");
  lock_blocks_a: assert property (lock_active_o |-> !$rose(prog_busy_o))
    else $error("programming while locked");
  lock_stable_a: assert property (up_cnt == 15 |-> $stable(lock_active_o))
    else $error("lock changed after power-up");
  cover property ($fell(out_pin_oe_o) && hi_cnt > 2 * TPOUT_CYCLES);
  cover property ($rose(prog_busy_o));
  cover property ($fell(sensor_active_o));
  cover property ($rose(lock_active_o));
endmodule

bind sensor_programming_telegram telegram_sva #(
  .TPOUT_CYCLES(TPOUT_CYCLES),
  .TPROG_CYCLES(TPROG_CYCLES)
) telegram_sva_inst (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .supply_high_i(supply_high_i),
  .out_pin_i(out_pin_i),
  .out_pin_o(out_pin_o),
  .out_pin_oe_o(out_pin_oe_o),
  .sensor_active_o(sensor_active_o),
  .lock_active_o(lock_active_o),
  .prog_busy_o(prog_busy_o)
);

// *** programmer_model.sv ***
// programmer model: modulates the supply level and reads replies on the output pin
// assumes the core clock, bit period 50 cycles, reply bit 100 cycles, pulled-down pin
module programmer_model (
  // clock
  input wire logic clk_i,
  // pin side
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic supply_o,
  output logic act_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // telegram tasks
  // ********************************
  initial begin
    supply_o = 1'b0;
    act_o = 1'b0;
  end
  // last bit stops after its falling edge, so the reply is not missed
  task automatic pulse(input logic b, input logic last);
    int hi;
    hi = b ? 33 : 17;
    for (int k = 0; k < (last ? hi + 1 : 50); k++) begin
      @(posedge clk_i);
      supply_o <= (k < hi);
    end
  endtask
  task automatic send(input logic [2:0] op, input logic [3:0] sel, input logic [13:0] d, input logic [2:0] bad);
    logic [23:0] bits;
    int n;
    bits = {op, ~^op ^ bad[0], sel, ^sel ^ bad[1], d, ~^d ^ bad[2]};
    n = (op == telegram_pkg::OP_WRITE) ? 24 : 9;
    repeat (150) @(posedge clk_i);
    pulse(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      pulse(bits[23 - i], i == n - 1);
    end
  endtask
  task automatic rx(input int n, output logic ok, output logic [15:0] v);
    int w;
    ok = 1'b0;
    v = 16'h0000;
    w = 0;
    while (pin_oe_i !== 1'b1 && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    if (pin_oe_i !== 1'b1) return;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      repeat (50) @(negedge clk_i);
      v[n - 1 - i] = pin_i;
      repeat (50) @(negedge clk_i);
    end
    w = 0;
    while (pin_oe_i === 1'b1 && w < 200) begin
      @(negedge clk_i);
      w++;
    end
  endtask
  task automatic activate();
    @(posedge clk_i);
    act_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    act_o <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench: telegrams through the programmer model, checks on replies and outputs
// assumes shortened bit, reply and program-wait counts set at the instance
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // signals and instances
  // ********************************
  logic core_clk, reset_n, supply_high, out_pin, out_pin_drv, out_pin_oe, act;
  logic sensor_active, lock_active, prog_busy;
  logic [13:0] adc_sample, dac_value, gain_setting;
  logic [7:0] low_clamp;
  logic [8:0] high_clamp;
  logic [10:0] quiescent;
  logic [2:0] range_select, tc_quad;
  logic [3:0] out_sel;
  logic [1:0] filter_select, tc_group;
  logic [4:0] tc_linear;
  logic [15:0] rsp;
  int miscompares = 0;
  int cmp_count = 0;
  logic [3:0] wsel [4] = '{telegram_pkg::ADDR_LOW_CLAMP, telegram_pkg::ADDR_GAIN, telegram_pkg::ADDR_CONFIG,
    telegram_pkg::ADDR_TEMP_COEFF};
  logic [13:0] wdat [4] = '{14'h3F5A, 14'h2ABC, 14'h3E5A, 14'h12CD};
  int wwid [4] = '{8, 14, 10, 10};
  logic [2:0] bop [7] = '{telegram_pkg::OP_WRITE, telegram_pkg::OP_WRITE, telegram_pkg::OP_WRITE, 3'h6,
    telegram_pkg::OP_WRITE, telegram_pkg::OP_READ, telegram_pkg::OP_ERASE};
  logic [3:0] bsel [7] = '{4'h5, 4'h5, 4'h5, 4'h5, telegram_pkg::ADDR_ADC, telegram_pkg::ADDR_DISABLE, 4'h1};
  logic [2:0] bbad [7] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
  // pulled down while neither side drives the pin
  assign out_pin = out_pin_oe ? out_pin_drv : act;
  sensor_programming_telegram #(.TP0_MIN_CYCLES(40), .TP0_MAX_CYCLES(60), .TPOUT_CYCLES(100), .TPROG_CYCLES(50))
  sensor_programming_telegram_inst (.core_clk_i(core_clk), .reset_n_i(reset_n), .supply_high_i(supply_high),
    .out_pin_i(out_pin), .out_pin_o(out_pin_drv), .out_pin_oe_o(out_pin_oe), .adc_sample_i(adc_sample),
    .dac_value_i(dac_value), .sensor_active_o(sensor_active), .lock_active_o(lock_active),
    .prog_busy_o(prog_busy), .low_clamp_level_o(low_clamp), .high_clamp_level_o(high_clamp),
    .quiescent_output_offset_o(quiescent), .gain_setting_o(gain_setting), .range_select_o(range_select),
    .output_behaviour_select_o(out_sel), .filter_select_o(filter_select), .tc_group_o(tc_group),
    .tc_linear_o(tc_linear), .quadratic_temp_coefficient_o(tc_quad));
  programmer_model programmer_model_inst (.clk_i(core_clk), .pin_i(out_pin), .pin_oe_i(out_pin_oe),
    .supply_o(supply_high), .act_o(act));
  // ********************************
  // tasks
  // ********************************
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [13:0] rev14(input logic [13:0] v);
    for (int i = 0; i < 14; i++) rev14[i] = v[13 - i];
  endfunction
  task automatic tel(input logic [2:0] op, input logic [3:0] sel, input logic [13:0] d, input logic [2:0] bad,
    input logic exp_ok);
    logic ok;
    programmer_model_inst.send(op, sel, d, bad);
    programmer_model_inst.rx(op == telegram_pkg::OP_READ ? 16 : 1, ok, rsp);
    `CHK(ok, exp_ok)
    if (ok === 1'b1) `CHK(rsp[op == telegram_pkg::OP_READ ? 15 : 0], 1'b0)
  endtask
  task automatic rd(input logic [3:0] sel, input logic [13:0] want, input logic exp_ok);
    tel(telegram_pkg::OP_READ, sel, 14'h0000, 3'h0, exp_ok);
    if (exp_ok) `CHK(rsp[14:1], want)
    if (exp_ok) `CHK(rsp[0], ~^want)
  endtask
  task automatic store(input logic exp_ok);
    int w;
    for (int j = 0; j < 2; j++) begin
      tel(j == 0 ? telegram_pkg::OP_ERASE : telegram_pkg::OP_PROGRAM, 4'h0, 14'h0000, 3'h0, exp_ok);
      repeat (3) @(negedge core_clk);
      `CHK(prog_busy, exp_ok)
      w = 0;
      while (prog_busy === 1'b1 && w < 200) begin
        @(negedge core_clk);
        w++;
      end
    end
  endtask
  // ********************************
  // clock, watchdog and test sequence
  // ********************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    adc_sample = 14'h2A5C;
    dac_value = 14'h0123;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    store(1'b1);
    for (int i = 0; i < 4; i++) tel(telegram_pkg::OP_WRITE, wsel[i], wdat[i], 3'h0, 1'b1);
    @(negedge core_clk);
    `CHK(low_clamp, 8'h5A)
    `CHK(gain_setting, 14'h2ABC)
    `CHK({range_select, out_sel, filter_select}, 9'h14B)
    `CHK({tc_group, tc_linear, tc_quad}, 10'h2CD)
    tel(telegram_pkg::OP_WRITE, telegram_pkg::ADDR_SCRATCH_FIRST, 14'h0ABC, 3'h0, 1'b1);
    store(1'b1);
    rd(telegram_pkg::ADDR_SCRATCH_FIRST, 14'h1578, 1'b1);
    for (int i = 0; i < 4; i++) rd(wsel[i], 14'(wdat[i] << (14 - wwid[i])), 1'b1);
    rd(telegram_pkg::ADDR_ADC, adc_sample, 1'b1);
    rd(telegram_pkg::ADDR_DAC, rev14(dac_value), 1'b1);
    for (int i = 0; i < 7; i++) tel(bop[i], bsel[i], 14'h0000, bbad[i], 1'b0);
    `CHK(range_select, 3'h5)
    tel(telegram_pkg::OP_WRITE, telegram_pkg::ADDR_DISABLE, 14'h080E, 3'h0, 1'b1);
    `CHK(sensor_active, 1'b1)
    tel(telegram_pkg::OP_WRITE, telegram_pkg::ADDR_DISABLE, 14'h080F, 3'h0, 1'b1);
    repeat (5) @(negedge core_clk);
    `CHK(sensor_active, 1'b0)
    rd(telegram_pkg::ADDR_CONFIG, 14'h0000, 1'b0);
    programmer_model_inst.activate();
    repeat (10) @(negedge core_clk);
    `CHK(sensor_active, 1'b1)
    tel(telegram_pkg::OP_WRITE, telegram_pkg::ADDR_PROTECT, 14'h0001, 3'h0, 1'b1);
    store(1'b1);
    `CHK(lock_active, 1'b0)
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(negedge core_clk);
    `CHK(lock_active, 1'b1)
    `CHK(range_select, 3'h5)
    store(1'b0);
    print_verdict();
  end
endmodule
